// [nvsram_host_pkg.sv]
package nvsram_host_pkg;

  // pin and counter widths
  localparam int ADDR_W = 15;
  localparam int SEQ_ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int TIMER_W = 18;
  localparam int STEP_W = 3;

  // clock and device timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACCESS_TIME_NS = 45;
  localparam int STORE_TIME_MS = 10;
  localparam int RECALL_TIME_US = 20;
  localparam int RESTORE_TIME_US = 550;

  // one extra strobe cycle because the data lines are sampled synchronously
  localparam int STROBE_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int STORE_CYC = (STORE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_CYC = (RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTORE_CYC = (RESTORE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // nonvolatile command sequence
  localparam logic [STEP_W-1:0] SEQ_FIRST = 3'h0;
  localparam logic [STEP_W-1:0] SEQ_LAST = 3'h5;
  localparam logic [STEP_W-1:0] SEQ_ONE = 3'h1;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_A0 = 14'h0E38;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_A1 = 14'h31C7;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_A2 = 14'h03E0;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_A3 = 14'h3C1F;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_A4 = 14'h303F;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_STORE_A5 = 14'h0FC0;
  localparam logic [SEQ_ADDR_W-1:0] SEQ_RECALL_A5 = 14'h0C63;
  localparam logic SEQ_TOP_BIT = 1'b0;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_STORE = 2'h2,
    OP_RECALL = 2'h3
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2,
    ST_WAIT_NV = 3'h6,
    ST_POWERUP = 3'h4
  } state_t;

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [STEP_W-1:0] step,
                                                 input logic is_store);
    logic [SEQ_ADDR_W-1:0] low;
    low = SEQ_A0;
    case (step)
      3'h0: low = SEQ_A0;
      3'h1: low = SEQ_A1;
      3'h2: low = SEQ_A2;
      3'h3: low = SEQ_A3;
      3'h4: low = SEQ_A4;
      default: low = is_store ? SEQ_STORE_A5 : SEQ_RECALL_A5;
    endcase
    return {SEQ_TOP_BIT, low};
  endfunction : seq_addr

endpackage : nvsram_host_pkg

// [op_timer.sv]
`timescale 1ns/1ps
module op_timer
  import nvsram_host_pkg::*;
#(
  parameter logic [TIMER_W-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic load_i,
  input wire logic [TIMER_W-1:0] load_val_i,
  // status
  output logic done_o
);

  logic [TIMER_W-1:0] count_r;
  logic [TIMER_W-1:0] count_nxt;
  wire logic at_zero = (count_r == '0);

  assign count_nxt = load_i ? load_val_i : (at_zero ? count_r : count_r - 1'b1);
  assign done_o = at_zero;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      count_r <= RST_VAL;
    else if (ce_i)
      count_r <= count_nxt;
  end

endmodule : op_timer

// [nvsram_store_recall_sequencer.sv]
// Contract
// - write enable high through every read, low for every write.
// - six consecutive accesses, prescribed order, write enable high, arm an operation.
// - every sequence step is a read terminated by chip select.
// - store: 0E38 31C7 03E0 3C1F 303F 0FC0; recall ends 0C63 instead.
`timescale 1ns/1ps
module nvsram_store_recall_sequencer
  import nvsram_host_pkg::*;
#(
  parameter int STORE_WAIT = STORE_CYC,
  parameter int RESTORE_WAIT = RESTORE_CYC
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic busy_o,
  // memory pins
  output logic chip_sel_n_o,
  output logic write_en_n_o,
  output logic out_en_n_o,
  output logic [ADDR_W-1:0] low_address_bits_o,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe_o
);

  // counts load one short because the cycle at zero is counted too
  localparam logic [TIMER_W-1:0] STROBE_LOAD = TIMER_W'(STROBE_CYC - 1);
  localparam logic [TIMER_W-1:0] STORE_LOAD = TIMER_W'(STORE_WAIT - 1);
  localparam logic [TIMER_W-1:0] RECALL_LOAD = TIMER_W'(RECALL_CYC - 1);
  localparam logic [TIMER_W-1:0] RESTORE_LOAD = TIMER_W'(RESTORE_WAIT - 1);

  state_t state_r;
  state_t state_nxt;
  op_t op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [STEP_W-1:0] step_r;
  logic chip_sel_n_r;
  logic write_en_n_r;
  logic out_en_n_r;
  logic [ADDR_W-1:0] pin_addr_r;
  logic [DATA_W-1:0] pin_data_r;
  logic pin_data_oe_r;
  logic [DATA_W-1:0] rdata_r;
  logic rdata_valid_r;
  logic ready_r;
  logic busy_r;
  logic timer_done;

  // decode of the current and next access
  wire logic take = (state_r == ST_IDLE) && cmd_valid_i;
  wire op_t op_nxt = take ? op_t'(cmd_op_i) : op_r;
  wire logic [ADDR_W-1:0] addr_nxt = take ? cmd_addr_i : addr_r;
  wire logic is_nv = (op_r == OP_STORE) || (op_r == OP_RECALL);
  wire logic is_nv_nxt = (op_nxt == OP_STORE) || (op_nxt == OP_RECALL);
  wire logic last_step = (step_r == SEQ_LAST);
  wire logic step_adv = (state_r == ST_HOLD) && is_nv && !last_step;
  wire logic [STEP_W-1:0] step_nxt = take ? SEQ_FIRST : (step_adv ? step_r + SEQ_ONE : step_r);
  wire logic is_write_nxt = (op_nxt == OP_WRITE);
  wire logic in_access_nxt = (state_nxt == ST_SETUP) || (state_nxt == ST_STROBE)
                             || (state_nxt == ST_HOLD);
  // the top bit is forced low; only the low 14 bits matter to the detector
  wire logic [ADDR_W-1:0] pin_addr_nxt = is_nv_nxt ? seq_addr(step_nxt, op_nxt == OP_STORE)
                                                   : addr_nxt;
  // write enable goes low in setup, before chip select falls
  wire logic write_en_n_nxt = !(in_access_nxt && is_write_nxt);
  // each access ends when chip select rises
  wire logic chip_sel_n_nxt = !(state_nxt == ST_STROBE);
  // output enable only for plain reads; sequence reads do not need it
  wire logic out_en_n_nxt = !((state_nxt == ST_STROBE) && (op_nxt == OP_READ));
  // write data stays driven until write enable rises, so the hold time is met
  wire logic data_oe_nxt = is_write_nxt && ((state_nxt == ST_STROBE) || (state_nxt == ST_HOLD));
  // data is taken on the last strobe edge, one cycle past the access time
  wire logic capture = (state_r == ST_STROBE) && timer_done && (op_r == OP_READ);
  wire logic nv_start = (state_r == ST_HOLD) && is_nv && last_step;
  wire logic timer_load = (state_r == ST_SETUP) || nv_start;
  wire logic [TIMER_W-1:0] timer_val = (state_r == ST_SETUP) ? STROBE_LOAD
                                     : ((op_r == OP_STORE) ? STORE_LOAD : RECALL_LOAD);

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (take)
          state_nxt = ST_SETUP;
      end
      ST_SETUP:
        state_nxt = ST_STROBE;
      ST_STROBE:
      begin
        if (timer_done)
          state_nxt = ST_HOLD;
      end
      ST_HOLD:
      begin
        // the six reads run back to back so nothing can intrude
        if (step_adv)
          state_nxt = ST_SETUP;
        else if (nv_start)
          state_nxt = ST_WAIT_NV;
        else
          state_nxt = ST_IDLE;
      end
      ST_WAIT_NV:
      begin
        // pins stay idle for the whole store or recall duration
        if (timer_done)
          state_nxt = ST_IDLE;
      end
      ST_POWERUP:
      // reset stands in for the supply crossing the trigger level
      begin
        if (timer_done)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // one down-counter times the strobe, the nv waits and the power-up reload
  op_timer #(
    .RST_VAL(RESTORE_LOAD)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(timer_load),
    .load_val_i(timer_val),
    .done_o(timer_done)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_POWERUP;
      op_r <= OP_READ;
      addr_r <= '0;
      wdata_r <= '0;
      step_r <= SEQ_FIRST;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      step_r <= step_nxt;
      if (take)
        wdata_r <= cmd_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chip_sel_n_r <= 1'b1;
      write_en_n_r <= 1'b1;
      out_en_n_r <= 1'b1;
      pin_addr_r <= '0;
      pin_data_r <= '0;
      pin_data_oe_r <= 1'b0;
    end
    else if (ce_i)
    begin
      chip_sel_n_r <= chip_sel_n_nxt;
      write_en_n_r <= write_en_n_nxt;
      out_en_n_r <= out_en_n_nxt;
      pin_addr_r <= pin_addr_nxt;
      pin_data_r <= take ? cmd_wdata_i : wdata_r;
      pin_data_oe_r <= data_oe_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_r <= '0;
      rdata_valid_r <= 1'b0;
      ready_r <= 1'b0;
      busy_r <= 1'b1;
    end
    else if (ce_i)
    begin
      if (capture)
        rdata_r <= data_lines_i;
      rdata_valid_r <= capture;
      ready_r <= (state_nxt == ST_IDLE);
      busy_r <= (state_nxt == ST_WAIT_NV) || (state_nxt == ST_POWERUP);
    end
  end

  // the device reports no completion, so busy spans the worst-case duration
  assign cmd_ready_o = ready_r;
  assign rdata_o = rdata_r;
  assign rdata_valid_o = rdata_valid_r;
  assign busy_o = busy_r;
  assign chip_sel_n_o = chip_sel_n_r;
  assign write_en_n_o = write_en_n_r;
  assign out_en_n_o = out_en_n_r;
  assign low_address_bits_o = pin_addr_r;
  assign data_lines_o = pin_data_r;
  assign data_lines_oe_o = pin_data_oe_r;

endmodule : nvsram_store_recall_sequencer

// [nvsram_store_recall_sequencer_sva.sv]
`timescale 1ns/1ps
module nvsram_seq_sva
  import nvsram_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // status
  input wire logic rdata_valid_o,
  input wire logic busy_o,
  // memory pins
  input wire logic chip_sel_n_o,
  input wire logic write_en_n_o,
  input wire logic out_en_n_o,
  input wire logic [ADDR_W-1:0] low_address_bits_o,
  input wire logic data_lines_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic [ADDR_W-1:0] adr = low_address_bits_o;
  // sequence reads keep output enable high, which tells them from user reads
  sequence s_first;
    $fell(chip_sel_n_o) && out_en_n_o && write_en_n_o && adr == 15'h0E38;
  endsequence
  sequence s_rest;
    ##5 adr == 15'h31C7 ##5 adr == 15'h03E0 ##5 adr == 15'h3C1F ##5 adr == 15'h303F
    ##5 adr inside {15'h0FC0, 15'h0C63};
  endsequence
  a_seq_order: assert property (s_first |-> s_rest ##[1:6] busy_o)
    else $error("command sequence wrong");
  a_seq_we_high: assert property (s_first |-> write_en_n_o throughout s_rest)
    else $error("write enable low in sequence");
  a_read_pulse: assert property ($fell(chip_sel_n_o) && !out_en_n_o |->
    ##3 rdata_valid_o ##1 !rdata_valid_o) else $error("read data pulse wrong");
  a_cs_width: assert property ($fell(chip_sel_n_o) |->
    !chip_sel_n_o [*3] ##1 chip_sel_n_o) else $error("chip select width wrong");
  a_we_before_cs: assert property ($fell(chip_sel_n_o) && !write_en_n_o |->
    !$past(write_en_n_o)) else $error("write enable late");
  a_read_we_high: assert property (!out_en_n_o |-> write_en_n_o && !data_lines_oe_o)
    else $error("read with write enable low");
  a_write_drive: assert property (!chip_sel_n_o && !write_en_n_o |-> data_lines_oe_o)
    else $error("write data not driven");
  a_busy_quiet: assert property (busy_o |-> chip_sel_n_o && !data_lines_oe_o)
    else $error("pins active while busy");
endmodule : nvsram_seq_sva

bind nvsram_store_recall_sequencer nvsram_seq_sva chk_u (.*);

// [nvsram_dev_model.sv]
`timescale 1ns/1ps
module nvsram_dev_model
#(
  parameter int STORE_NS = 600,
  parameter int RECALL_NS = 15000,
  parameter int RESTORE_NS = 300
)
(
  // supply rise stand-in
  input wire logic rst_i,
  // memory pins
  input wire logic chip_sel_n_i,
  input wire logic write_en_n_i,
  input wire logic out_en_n_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:32767];
  logic [7:0] nv [0:32767];
  logic [2:0] step_r = 3'h0;
  logic busy_r = 1'b0;
  logic [13:0] seq_a [0:4] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
  task automatic nv_op(input bit store, input int ns);
    busy_r = 1'b1;
    if (store)
      nv = mem;
    else
    begin
      mem = '{default: 8'h00};
      mem = nv;
    end
    #(ns);
    busy_r = 1'b0;
  endtask : nv_op
  always @(negedge rst_i) nv_op(1'b0, RESTORE_NS);
  // only the low 14 bits take part in matching
  always @(negedge chip_sel_n_i)
    if (!busy_r)
    begin
      if (!write_en_n_i)
        step_r = 3'h0;
      else if (step_r == 3'h5 && addr_i[13:0] inside {14'h0FC0, 14'h0C63})
      begin
        step_r = 3'h0;
        nv_op(addr_i[13:0] == 14'h0FC0, (addr_i[13:0] == 14'h0FC0) ? STORE_NS : RECALL_NS);
      end
      else if (step_r < 3'h5 && addr_i[13:0] == seq_a[step_r])
        step_r = step_r + 3'h1;
      else
        step_r = (addr_i[13:0] == 14'h0E38) ? 3'h1 : 3'h0;
    end
  always @(posedge chip_sel_n_i)
    if (!write_en_n_i && !busy_r)
      mem[addr_i] = data_i;
  // undriven lines show the inverse so stale data never passes
  always @*
    if (!chip_sel_n_i && !out_en_n_i && write_en_n_i && !busy_r)
      data_o = mem[addr_i];
    else
      data_o = ~mem[addr_i];
endmodule : nvsram_dev_model

// [nvsram_store_recall_sequencer_test.sv]
`timescale 1ns/1ps
module nvsram_store_recall_sequencer_test;
  import nvsram_host_pkg::*;
  localparam int RW = 10;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_op_i = 2'h0;
  logic [ADDR_W-1:0] cmd_addr_i = 15'h0000;
  logic [DATA_W-1:0] cmd_wdata_i = 8'h00;
  logic cmd_ready_o, rdata_valid_o, busy_o, chip_sel_n_o, write_en_n_o, out_en_n_o;
  logic data_lines_oe_o;
  logic [ADDR_W-1:0] low_address_bits_o;
  logic [DATA_W-1:0] rdata_o, data_lines_o, data_lines_i, dev_q;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  assign data_lines_i = data_lines_oe_o ? data_lines_o : dev_q;
  nvsram_store_recall_sequencer #(.STORE_WAIT(20), .RESTORE_WAIT(RW)) dut_u (.*);
  nvsram_dev_model dev_u (.rst_i(rst_i), .chip_sel_n_i(chip_sel_n_o),
    .write_en_n_i(write_en_n_o), .out_en_n_i(out_en_n_o), .addr_i(low_address_bits_o),
    .data_i(data_lines_o), .data_o(dev_q));
  initial forever #20 sys_clk_i = ~sys_clk_i;
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 2000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    check("ready", 8'h01, {7'h00, cmd_ready_o});
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_wdata_i <= d;
    cmd_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
  endtask : cmd
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    cmd(OP_READ, a, 8'h00);
    while (rdata_valid_o !== 1'b1 && n < 10)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    check("read valid", 8'h01, {7'h00, rdata_valid_o});
    check("read data", exp, rdata_o);
  endtask : rd
  task automatic t_powerup();
    repeat (RW - 2) @(posedge sys_clk_i);
    check("early ready", 8'h01, {7'h00, busy_o});
    repeat (3) @(posedge sys_clk_i);
    check("reload done", 8'h00, {7'h00, busy_o});
  endtask : t_powerup
  task automatic t_write_read();
    cmd(OP_WRITE, 15'h1234, 8'hA5);
    cmd(OP_WRITE, 15'h7235, 8'h5A);
    rd(15'h1234, 8'hA5);
    rd(15'h7235, 8'h5A);
  endtask : t_write_read
  task automatic t_store_recall();
    cmd(OP_WRITE, 15'h0100, 8'h3C);
    cmd(OP_STORE, 15'h0000, 8'h00);
    cmd(OP_WRITE, 15'h0100, 8'h00);
    rd(15'h0100, 8'h00);
    cmd(OP_RECALL, 15'h0000, 8'h00);
    rd(15'h0100, 8'h3C);
    // no write since the recall: the store must still be issued
    cmd(OP_STORE, 15'h0000, 8'h00);
    repeat (35) @(posedge sys_clk_i);
    check("store busy", 8'h01, {7'h00, busy_o});
    cmd(OP_WRITE, 15'h0100, 8'h77);
    cmd(OP_RECALL, 15'h0000, 8'h00);
    rd(15'h0100, 8'h3C);
  endtask : t_store_recall
  task automatic t_abort();
    cmd(OP_READ, 15'h0E38, 8'h00);
    cmd(OP_READ, 15'h31C7, 8'h00);
    cmd(OP_WRITE, 15'h0200, 8'h11);
    rd(15'h0200, 8'h11);
    cmd(OP_WRITE, 15'h0100, 8'h99);
    cmd(OP_RECALL, 15'h0000, 8'h00);
    rd(15'h0100, 8'h3C);
  endtask : t_abort
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_powerup();
    t_write_read();
    t_store_recall();
    t_abort();
    report_and_stop();
  end
endmodule : nvsram_store_recall_sequencer_test
